//--- bat_host.sv
// Controller end: AXI4-Lite orders turned into sub CPU bus cycles
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module bat_host (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Interrupt
	output logic irq,
	// Sub CPU bus
	bat_if.cpu bus
);
	typedef enum logic [1:0] {BAT_IDLE, BAT_DRIVE, BAT_SETTLE} bat_st_e;

	typedef struct packed {
		bat_st_e st;
		bat_pkg::bat_op_e op;
		logic [7:0] base;
		logic [23:0] cdata;
		logic [1:0] idx;
		logic [1:0] nb;
		logic strb;
		logic we;
		logic dsel;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rd_byte;
		logic [1:0] int_stat;
		logic [1:0] int_mask;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bat_host_s;

	bat_host_s st_r;
	bat_host_s st_nxt;
	logic wr_go;
	logic [1:0] set_ev;

	// Byte lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// Byte i of a multi-byte load, most significant first
	function automatic logic [7:0] pick(input logic [23:0] d,
		input logic [1:0] nb, input logic [1:0] i, input logic [7:0] base);
		logic [7:0] b;
		b = d[(int'(nb) - 1 - int'(i)) * 8 +: 8];
		if (nb == 2'd3 && i == 2'd0)
			b = b & bat_pkg::HI20_MASK;
		else if (nb == 2'd2 && i == 2'd0 && base != bat_pkg::A_TMR_H)
			b = b & bat_pkg::HI11_MASK;
		return b;
	endfunction

	assign wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;

	always_comb begin
		st_nxt = st_r;
		set_ev = 2'b00;
		set_ev[bat_pkg::INT_TIMER] = bus.timer_event;
		// ********************************
		// Bus sequencer
		// ********************************
		unique case (st_r.st)
			BAT_IDLE: ;
			BAT_DRIVE: begin
				st_nxt.strb = 1'b0;
				st_nxt.st = BAT_SETTLE;
			end
			BAT_SETTLE: begin
				if (!st_r.we)
					st_nxt.rd_byte = bus.rdata;
				if (st_r.idx + 2'd1 < st_r.nb) begin
					// Next byte, keeping high-to-low order
					st_nxt.idx = st_r.idx + 2'd1;
					st_nxt.addr = st_r.base + 8'(st_r.idx) + 8'd1;
					st_nxt.wdata = pick(st_r.cdata, st_r.nb, st_nxt.idx,
						st_r.base);
					st_nxt.strb = 1'b1;
					st_nxt.st = BAT_DRIVE;
				end else begin
					st_nxt.st = BAT_IDLE;
					set_ev[bat_pkg::INT_DONE] = 1'b1;
				end
			end
		endcase
		// ********************************
		// AXI4-Lite write side
		// ********************************
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wd = s_axi_wdata;
			st_nxt.ws = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready)
			st_nxt.bvalid = 1'b0;
		if (wr_go) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = bat_pkg::RESP_OKAY;
			unique case (st_r.awaddr)
				bat_pkg::R_CMD: if (st_r.st == BAT_IDLE) begin
					st_nxt.op = bat_pkg::bat_op_e'(
						st_r.wd[bat_pkg::CMD_OP_LSB +: 3]);
					st_nxt.base = st_r.wd[7:0];
					st_nxt.idx = 2'd0;
					st_nxt.we = 1'b1;
					st_nxt.dsel = 1'b0;
					st_nxt.nb = 2'd1;
					unique case (st_nxt.op)
						bat_pkg::BAT_OP_RD: st_nxt.we = 1'b0;
						bat_pkg::BAT_OP_BUFWR: st_nxt.dsel = 1'b1;
						bat_pkg::BAT_OP_BUFRD: begin
							st_nxt.we = 1'b0;
							st_nxt.dsel = 1'b1;
						end
						bat_pkg::BAT_OP_WR3: st_nxt.nb = 2'd3;
						bat_pkg::BAT_OP_WR2: st_nxt.nb = 2'd2;
						default: ;
					endcase
					st_nxt.addr = st_nxt.base;
					st_nxt.wdata = pick(st_r.cdata, st_nxt.nb, 2'd0,
						st_nxt.base);
					st_nxt.strb = 1'b1;
					st_nxt.st = BAT_DRIVE;
				end
				bat_pkg::R_DATA:
					st_nxt.cdata = 24'(merge(32'(st_r.cdata), st_r.wd,
						st_r.ws));
				bat_pkg::R_INT:
					st_nxt.int_stat = st_r.int_stat & ~st_r.wd[1:0];
				bat_pkg::R_MASK:
					st_nxt.int_mask = 2'(merge(32'(st_r.int_mask), st_r.wd,
						st_r.ws));
				default: st_nxt.bresp = bat_pkg::RESP_SLVERR;
			endcase
		end
		// Hardware set wins over a same-cycle clear
		st_nxt.int_stat = st_nxt.int_stat | set_ev;
		// ********************************
		// AXI4-Lite read side
		// ********************************
		if (st_r.rvalid && s_axi_rready)
			st_nxt.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = bat_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				bat_pkg::R_CMD: st_nxt.rdata = {21'h0, st_r.op, st_r.base};
				bat_pkg::R_DATA: st_nxt.rdata = {8'h00, st_r.cdata};
				bat_pkg::R_STAT: st_nxt.rdata = {16'h0, st_r.rd_byte, 7'h00,
					st_r.st != BAT_IDLE};
				bat_pkg::R_INT: st_nxt.rdata = {30'h0, st_r.int_stat};
				bat_pkg::R_MASK: st_nxt.rdata = {30'h0, st_r.int_mask};
				default: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rresp = bat_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_have && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign irq = |(st_r.int_stat & st_r.int_mask);
	assign bus.strb = st_r.strb;
	assign bus.we = st_r.we;
	assign bus.data_sel = st_r.dsel;
	assign bus.addr = st_r.addr;
	assign bus.wdata = st_r.wdata;
endmodule // bat_host

//--- bat_pkg.sv
// Shared constants and types for the buffer access and timer register block
package bat_pkg;

	// ********************************
	// Device register offsets
	// ********************************
	localparam logic [7:0] A_WPTR_H = 8'h3F;
	localparam logic [7:0] A_WPTR_M = 8'h40;
	localparam logic [7:0] A_WPTR_L = 8'h41;
	localparam logic [7:0] A_RPTR_H = 8'h43;
	localparam logic [7:0] A_RPTR_M = 8'h44;
	localparam logic [7:0] A_RPTR_L = 8'h45;
	localparam logic [7:0] A_BLK_H = 8'h46;
	localparam logic [7:0] A_BLK_L = 8'h47;
	localparam logic [7:0] A_FILL_H = 8'h48;
	localparam logic [7:0] A_FILL_L = 8'h49;
	localparam logic [7:0] A_TMR_H = 8'h4A;
	localparam logic [7:0] A_TMR_L = 8'h4B;
	localparam logic [7:0] A_SCALE = 8'h4C;
	localparam logic [7:0] A_ORIG_H = 8'h4E;
	localparam logic [7:0] A_ORIG_L = 8'h4F;

	// ********************************
	// Field widths, masks, timing
	// ********************************
	localparam int PTR_W = 20;
	localparam int BLK_W = 11;
	localparam int FILL_W = 11;
	localparam int AREA_W = 9;
	localparam int TICK_MULT = 16;
	localparam logic [7:0] HI20_MASK = 8'h0F;
	localparam logic [7:0] HI11_MASK = 8'h07;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ********************************
	// Controller registers (AXI4-Lite)
	// ********************************
	localparam logic [7:0] R_CMD = 8'h00;
	localparam logic [7:0] R_DATA = 8'h04;
	localparam logic [7:0] R_STAT = 8'h08;
	localparam logic [7:0] R_INT = 8'h0C;
	localparam logic [7:0] R_MASK = 8'h10;
	localparam int CMD_OP_LSB = 8;
	localparam int INT_DONE = 0;
	localparam int INT_TIMER = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BAT_OP_WR, BAT_OP_RD, BAT_OP_BUFWR, BAT_OP_BUFRD, BAT_OP_WR3, BAT_OP_WR2
	} bat_op_e;

endpackage

//--- bat_if.sv
// Sub CPU register and buffer data bus between controller and device
`timescale 1ns/10ps
interface bat_if;
	logic strb;
	logic we;
	logic data_sel;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic timer_event;

	modport dev (input strb, we, data_sel, addr, wdata,
		output rdata, timer_event);
	modport cpu (output strb, we, data_sel, addr, wdata,
		input rdata, timer_event);
endinterface

//--- bat_timer.sv
// One-shot countdown with a scaled tick prescaler
`timescale 1ns/10ps
module bat_timer #(
	parameter int COUNT_W = 16,
	parameter int SCALE_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic start,
	input wire logic [COUNT_W-1:0] count,
	input wire logic [SCALE_W-1:0] scale,
	// Event
	output logic expire
);
	localparam int PRE_W = SCALE_W + $clog2(bat_pkg::TICK_MULT);

	if (COUNT_W < 1 || SCALE_W < 1)
		$error("bat_timer: widths must be positive");

	typedef struct packed {
		logic run;
		logic [COUNT_W-1:0] rem;
		logic [PRE_W-1:0] pre;
		logic fire;
	} bat_tmr_s;

	bat_tmr_s st_r;
	bat_tmr_s st_nxt;
	logic [PRE_W-1:0] reload;

	// Scale of zero wraps to the longest tick rather than stalling
	assign reload = PRE_W'(scale * bat_pkg::TICK_MULT) - PRE_W'(1);

	always_comb begin
		st_nxt = st_r;
		st_nxt.fire = 1'b0;
		if (start) begin
			st_nxt.run = 1'b1;
			st_nxt.rem = count;
			st_nxt.pre = reload;
		end else if (st_r.run) begin
			if (st_r.rem == '0) begin
				st_nxt.run = 1'b0;
				st_nxt.fire = 1'b1;
			end else if (st_r.pre == '0) begin
				st_nxt.rem = st_r.rem - COUNT_W'(1);
				st_nxt.pre = reload;
			end else begin
				st_nxt.pre = st_r.pre - PRE_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire = st_r.fire;
endmodule // bat_timer

//--- bat_dev.sv
// Device end: buffer pointers, block counter, fill ratio, timer registers
`timescale 1ns/10ps
module bat_dev #(
	parameter int PTR_W = bat_pkg::PTR_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sub CPU bus
	bat_if.dev bus,
	// Buffer memory
	output logic mem_we,
	output logic [PTR_W-1:0] mem_waddr,
	output logic [7:0] mem_wdata,
	output logic [PTR_W-1:0] mem_raddr,
	input wire logic [7:0] mem_rdata,
	// Decoder data path
	input wire logic sector_wr,
	input wire logic sector_transferable_flag,
	input wire logic [1:0] increment_size_setting,
	input wire logic block_done,
	input wire logic [bat_pkg::AREA_W-1:0] stream_origin_area,
	// Status out
	output logic [bat_pkg::BLK_W-1:0] ready_block_counter,
	output logic [bat_pkg::FILL_W-1:0] buffer_fill_ratio
);
	localparam int BW = bat_pkg::BLK_W;
	localparam int FW = bat_pkg::FILL_W;

	if (PTR_W <= 16 || PTR_W > 24)
		$error("bat_dev: PTR_W must be 17 to 24");

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [BW-1:0] blk;
		logic [FW-1:0] fill;
		logic [7:0] tmr_hi;
		logic [7:0] tmr_lo;
		logic [7:0] scale;
		logic [bat_pkg::AREA_W-1:0] origin;
		logic [7:0] rdata;
		logic we;
		logic [PTR_W-1:0] waddr;
		logic [7:0] wdata;
		logic tstart;
	} bat_dev_s;

	bat_dev_s st_r;
	bat_dev_s st_nxt;
	logic reg_wr;
	logic reg_rd;
	logic buf_wr;
	logic buf_rd;
	logic [BW-1:0] blk_inc;
	logic [7:0] rd_mux;

	// Upper pointer byte, padded with zero above the pointer width
	function automatic logic [7:0] hi_byte(input logic [PTR_W-1:0] p);
		logic [23:0] w;
		w = 24'(p);
		return w[23:16];
	endfunction

	// ********************************
	// Bus decode
	// ********************************
	// Address is ignored on buffer data strobes
	assign reg_wr = bus.strb && bus.we && !bus.data_sel;
	assign reg_rd = bus.strb && !bus.we && !bus.data_sel;
	assign buf_wr = bus.strb && bus.we && bus.data_sel;
	assign buf_rd = bus.strb && !bus.we && bus.data_sel;
	assign blk_inc = BW'(increment_size_setting) + BW'(1);

	// ********************************
	// Register read mux
	// ********************************
	always_comb begin
		unique case (bus.addr)
			bat_pkg::A_WPTR_H: rd_mux = hi_byte(st_r.wptr);
			bat_pkg::A_WPTR_M: rd_mux = st_r.wptr[15:8];
			bat_pkg::A_WPTR_L: rd_mux = st_r.wptr[7:0];
			bat_pkg::A_RPTR_H: rd_mux = hi_byte(st_r.rptr);
			bat_pkg::A_RPTR_M: rd_mux = st_r.rptr[15:8];
			bat_pkg::A_RPTR_L: rd_mux = st_r.rptr[7:0];
			// Live counter; a read may trail a same-cycle update
			bat_pkg::A_BLK_H: rd_mux = 8'(st_r.blk[BW-1:8]);
			bat_pkg::A_BLK_L: rd_mux = st_r.blk[7:0];
			bat_pkg::A_FILL_H: rd_mux = 8'(st_r.fill[FW-1:8]);
			bat_pkg::A_FILL_L: rd_mux = st_r.fill[7:0];
			bat_pkg::A_TMR_H: rd_mux = st_r.tmr_hi;
			bat_pkg::A_TMR_L: rd_mux = st_r.tmr_lo;
			bat_pkg::A_SCALE: rd_mux = st_r.scale;
			bat_pkg::A_ORIG_H: rd_mux = 8'(st_r.origin[8]);
			bat_pkg::A_ORIG_L: rd_mux = st_r.origin[7:0];
			default: rd_mux = bat_pkg::RESET_BYTE;
		endcase
	end

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.we = 1'b0;
		st_nxt.tstart = 1'b0;
		st_nxt.origin = stream_origin_area;
		// Counter events; a simultaneous add and subtract both apply
		if (sector_wr && sector_transferable_flag)
			st_nxt.blk = st_nxt.blk + blk_inc;
		if (block_done)
			st_nxt.blk = st_nxt.blk - BW'(1);
		if (buf_wr) begin
			st_nxt.we = 1'b1;
			st_nxt.waddr = st_r.wptr;
			st_nxt.wdata = bus.wdata;
			st_nxt.wptr = st_r.wptr + PTR_W'(1);
		end
		if (buf_rd) begin
			st_nxt.rdata = mem_rdata;
			st_nxt.rptr = st_r.rptr + PTR_W'(1);
		end
		if (reg_rd)
			st_nxt.rdata = rd_mux;
		// A CPU write to a byte overrides any event in that cycle
		if (reg_wr) begin
			unique case (bus.addr)
				bat_pkg::A_WPTR_H:
					st_nxt.wptr[PTR_W-1:16] = (PTR_W-16)'(bus.wdata);
				bat_pkg::A_WPTR_M: st_nxt.wptr[15:8] = bus.wdata;
				bat_pkg::A_WPTR_L: st_nxt.wptr[7:0] = bus.wdata;
				bat_pkg::A_RPTR_H:
					st_nxt.rptr[PTR_W-1:16] = (PTR_W-16)'(bus.wdata);
				bat_pkg::A_RPTR_M: st_nxt.rptr[15:8] = bus.wdata;
				bat_pkg::A_RPTR_L: st_nxt.rptr[7:0] = bus.wdata;
				bat_pkg::A_BLK_H:
					st_nxt.blk[BW-1:8] = (BW-8)'(bus.wdata);
				bat_pkg::A_BLK_L: st_nxt.blk[7:0] = bus.wdata;
				bat_pkg::A_FILL_H:
					st_nxt.fill[FW-1:8] = (FW-8)'(bus.wdata);
				bat_pkg::A_FILL_L: st_nxt.fill[7:0] = bus.wdata;
				bat_pkg::A_TMR_H: st_nxt.tmr_hi = bus.wdata;
				bat_pkg::A_TMR_L: begin
					st_nxt.tmr_lo = bus.wdata;
					st_nxt.tstart = 1'b1;
				end
				bat_pkg::A_SCALE: st_nxt.scale = bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ********************************
	// Timer
	// ********************************
	// Count is taken from the registers a cycle after the low write
	bat_timer #(
		.COUNT_W(16),
		.SCALE_W(8)
	) bat_timer_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(st_r.tstart),
		.count({st_r.tmr_hi, st_r.tmr_lo}),
		.scale(st_r.scale),
		.expire(bus.timer_event)
	);

	// ********************************
	// Outputs
	// ********************************
	assign bus.rdata = st_r.rdata;
	assign mem_we = st_r.we;
	assign mem_waddr = st_r.waddr;
	assign mem_wdata = st_r.wdata;
	assign mem_raddr = st_r.rptr;
	assign ready_block_counter = st_r.blk;
	assign buffer_fill_ratio = st_r.fill;
endmodule // bat_dev

//--- bat_props.sv
// Assertions on the sub CPU bus between controller and device
`timescale 1ns/10ps
module bat_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sub CPU bus
	input wire logic strb,
	input wire logic we,
	input wire logic data_sel,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic timer_event
);
	// ****************
	// Helper state
	// ****************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] last_r;
	logic armed_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_r <= 8'h00;
			armed_r <= 1'b0;
		end else begin
			if (strb && we && !data_sel)
				last_r <= addr;
			// New low-byte write wins over an event in the same cycle
			if (strb && we && !data_sel && addr == bat_pkg::A_TMR_L)
				armed_r <= 1'b1;
			else if (timer_event)
				armed_r <= 1'b0;
		end
	end
	sequence s_wr(logic [7:0] a);
		strb && we && !data_sel && addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		strb && !we && !data_sel && addr == a;
	endsequence
	// ****************
	// Properties
	// ****************
	AST_STRB_PULSE: assert property (strb |=> !strb)
		else $error("strobe longer than one cycle");
	AST_WPTR_ORDER: assert property
		(s_wr(bat_pkg::A_WPTR_M) |-> last_r == bat_pkg::A_WPTR_H)
		else $error("write pointer middle byte out of order");
	AST_RPTR_ORDER: assert property
		(s_wr(bat_pkg::A_RPTR_L) |-> last_r == bat_pkg::A_RPTR_M)
		else $error("read pointer low byte out of order");
	AST_WPTR_HI: assert property
		(s_wr(bat_pkg::A_WPTR_H) |-> wdata[7:4] == 4'h0)
		else $error("write pointer high nibble not zero");
	AST_RPTR_HI: assert property
		(s_wr(bat_pkg::A_RPTR_H) |-> wdata[7:4] == 4'h0)
		else $error("read pointer high nibble not zero");
	AST_BLK_HI: assert property
		(s_wr(bat_pkg::A_BLK_H) |-> wdata[7:3] == 5'h00)
		else $error("block count high bits not zero");
	AST_TMR_ORDER: assert property
		(s_wr(bat_pkg::A_TMR_L) |-> last_r == bat_pkg::A_TMR_H)
		else $error("timer low byte before high byte");
	AST_ONE_SHOT: assert property
		(timer_event |-> armed_r ##1 !timer_event)
		else $error("timer event without a pending start");
	AST_ORIG_RD: assert property
		(s_rd(bat_pkg::A_ORIG_H) |=> rdata[7:1] == 7'h00)
		else $error("origin area high byte wider than one bit");
	AST_FILL_RD: assert property
		(s_rd(bat_pkg::A_FILL_H) |=> rdata[7:3] == 5'h00)
		else $error("fill ratio high byte wider than three bits");
	AST_BLK_RD: assert property
		(s_rd(bat_pkg::A_BLK_H) |=> rdata[7:3] == 5'h00)
		else $error("block count high byte wider than three bits");
	AST_UNMAP_RD: assert property (s_rd(8'h42) |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property
		(!$stable(rdata) |-> $past(strb) && !$past(we))
		else $error("read byte changed without a read");
endmodule // bat_props

//--- buffer_access_timer_regs_tb_top.sv
// Bench joining controller and device, driven over AXI4-Lite
`timescale 1ns/10ps
module buffer_access_timer_regs_tb_top;
	// ****************
	// Signals
	// ****************
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0] r;
	} bat_note_s;
	logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq;
	logic [7:0] awa, ara, mwd, mrd;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp, inc;
	logic mem_we, sector_wr, flag, block_done;
	logic [19:0] waddr, raddr;
	logic [8:0] org;
	logic [10:0] blk, fill;
	bat_note_s rq[$];
	bat_note_s nt;
	logic [1:0] bq[$];
	logic [27:0] mq[$];
	int n_mismatch, checked, n_evt, tcnt, last;
	integer seed = 32'hA6A3;
	// Buffer model: pattern from address, so every byte read is known
	assign mrd = raddr[7:0] ^ 8'h5A;
	bat_if bat_if_inst ();
	bat_host bat_host_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .irq(irq),
		.bus(bat_if_inst));
	bat_dev bat_dev_inst (.aclk(aclk), .aresetn(aresetn),
		.bus(bat_if_inst), .mem_we(mem_we), .mem_waddr(waddr),
		.mem_wdata(mwd), .mem_raddr(raddr), .mem_rdata(mrd),
		.sector_wr(sector_wr), .sector_transferable_flag(flag),
		.increment_size_setting(inc), .block_done(block_done),
		.stream_origin_area(org), .ready_block_counter(blk),
		.buffer_fill_ratio(fill));
	bat_props bat_props_inst (.aclk(aclk), .aresetn(aresetn),
		.strb(bat_if_inst.strb), .we(bat_if_inst.we),
		.data_sel(bat_if_inst.data_sel), .addr(bat_if_inst.addr),
		.wdata(bat_if_inst.wdata), .rdata(bat_if_inst.rdata),
		.timer_event(bat_if_inst.timer_event));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic ok, input string s);
		checked = checked + 1;
		if (ok !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0t %s", $time, s);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = bat_pkg::RESP_OKAY);
		@(posedge aclk);
		bq.push_back(er);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] d,
		input logic [1:0] er = bat_pkg::RESP_OKAY);
		@(posedge aclk);
		rq.push_back('{e, m, er});
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
		end while (!rv);
		d = rd;
		rr <= 1'b0;
	endtask
	task automatic stat(input logic [7:0] e);
		logic [31:0] d;
		axi_rd(bat_pkg::R_STAT, {16'h0000, e, 8'h00}, 32'h0000FF00, d);
	endtask
	task automatic cmd(input bat_pkg::bat_op_e op, input logic [7:0] off,
		input logic [23:0] v);
		logic [31:0] d;
		axi_wr(bat_pkg::R_DATA, {8'h00, v});
		axi_wr(bat_pkg::R_CMD, {21'h000000, op, off});
		do
			axi_rd(bat_pkg::R_STAT, 32'h0, 32'h0, d);
		while (d[0] !== 1'b0);
	endtask
	task automatic dev_rd(input logic [7:0] off, input logic [7:0] e);
		cmd(bat_pkg::BAT_OP_RD, off, 24'h000000);
		stat(e);
	endtask
	task automatic ev(input logic s, input logic f, input logic b,
		input logic [1:0] k);
		@(posedge aclk);
		sector_wr <= s;
		flag <= f;
		block_done <= b;
		inc <= k;
		@(posedge aclk);
		sector_wr <= 1'b0;
		block_done <= 1'b0;
	endtask
	task automatic wait_tmr();
		logic [31:0] d;
		do
			axi_rd(bat_pkg::R_INT, 32'h0, 32'h0, d);
		while (d[1] !== 1'b1);
	endtask
	// ****************
	// Monitors
	// ****************
	always @(posedge aclk) begin
		if (rv && rr) begin
			nt = rq.pop_front();
			chk((rd & nt.m) === nt.d && rresp === nt.r, "read answer");
		end
		if (bv && br)
			chk(bresp === bq.pop_front(), "write response");
		if (mem_we)
			chk({waddr, mwd} === mq.pop_front(), "buffer write");
	end
	// Interval from the low-byte strobe to each timer event
	always @(posedge aclk) begin
		if (bat_if_inst.strb && bat_if_inst.we && !bat_if_inst.data_sel
			&& bat_if_inst.addr == bat_pkg::A_TMR_L)
			tcnt = 0;
		else
			tcnt = tcnt + 1;
		if (bat_if_inst.timer_event === 1'b1) begin
			n_evt = n_evt + 1;
			last = tcnt;
		end
	end
	// ****************
	// Clock, watchdog, tests
	// ****************
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch = n_mismatch + 1;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		logic [31:0] d;
		logic [23:0] v;
		logic [19:0] p;
		logic [10:0] b;
		logic [7:0] x;
		{awv, wv, br, arv, rr, sector_wr, flag, block_done} <= 8'h00;
		{awa, ara, wd, inc, org} <= '0;
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(bat_pkg::R_INT, 32'h0, 32'h3, d);
		axi_rd(bat_pkg::R_MASK, 32'h0, 32'h3, d);
		axi_wr(8'h14, 32'hFFFFFFFF, bat_pkg::RESP_SLVERR);
		axi_rd(8'h14, 32'h0, 32'h0, d, bat_pkg::RESP_SLVERR);
		axi_wr(bat_pkg::R_MASK, 32'h2);
		axi_rd(bat_pkg::R_MASK, 32'h2, 32'h3, d);
		$display("test controller registers done");
		// Low byte near the top, so the steps carry into the middle byte
		v = 24'($random(seed));
		v[7:0] = 8'hFE;
		p = v[19:0];
		cmd(bat_pkg::BAT_OP_WR3, bat_pkg::A_WPTR_H, v);
		repeat (2) begin
			x = 8'($random(seed));
			mq.push_back({p, x});
			cmd(bat_pkg::BAT_OP_BUFWR, 8'h00, {16'h0000, x});
			p = p + 20'h1;
		end
		dev_rd(bat_pkg::A_WPTR_L, p[7:0]);
		dev_rd(bat_pkg::A_WPTR_M, p[15:8]);
		$display("test write pointer done");
		v = 24'($random(seed));
		v[7:0] = 8'hFF;
		p = v[19:0];
		cmd(bat_pkg::BAT_OP_WR3, bat_pkg::A_RPTR_H, v);
		repeat (2) begin
			cmd(bat_pkg::BAT_OP_BUFRD, 8'h00, 24'h000000);
			stat(p[7:0] ^ 8'h5A);
			p = p + 20'h1;
		end
		dev_rd(bat_pkg::A_RPTR_M, p[15:8]);
		dev_rd(bat_pkg::A_RPTR_H, {4'h0, p[19:16]});
		$display("test read pointer done");
		// Top bit clear keeps the count clear of wrap-around
		v = 24'($random(seed));
		v[10] = 1'b0;
		b = v[10:0];
		cmd(bat_pkg::BAT_OP_WR2, bat_pkg::A_BLK_H, v);
		for (int k = 0; k < 4; k++) begin
			ev(1'b1, 1'b1, 1'b0, 2'(k));
			b = b + 11'(k + 1);
		end
		ev(1'b1, 1'b0, 1'b0, 2'h3);
		ev(1'b0, 1'b0, 1'b1, 2'h0);
		b = b - 11'h001;
		ev(1'b1, 1'b1, 1'b1, 2'h1);
		b = b + 11'h001;
		@(posedge aclk);
		chk(blk === b, "block count output");
		// Counter read only with no events in flight, so no skew
		dev_rd(bat_pkg::A_BLK_L, b[7:0]);
		dev_rd(bat_pkg::A_BLK_H, {5'h00, b[10:8]});
		$display("test block counter done");
		v = 24'($random(seed));
		cmd(bat_pkg::BAT_OP_WR2, bat_pkg::A_FILL_H, v);
		dev_rd(bat_pkg::A_FILL_H, {5'h00, v[10:8]});
		dev_rd(bat_pkg::A_FILL_L, v[7:0]);
		chk(fill === v[10:0], "fill ratio output");
		org <= 9'($random(seed));
		@(posedge aclk);
		dev_rd(bat_pkg::A_ORIG_H, {7'h00, org[8]});
		cmd(bat_pkg::BAT_OP_WR, bat_pkg::A_ORIG_L, {16'h0, ~org[7:0]});
		dev_rd(bat_pkg::A_ORIG_L, org[7:0]);
		dev_rd(8'h42, 8'h00);
		$display("test fill ratio and origin done");
		axi_wr(bat_pkg::R_INT, 32'h3);
		cmd(bat_pkg::BAT_OP_WR, bat_pkg::A_SCALE, 24'h000002);
		cmd(bat_pkg::BAT_OP_WR2, bat_pkg::A_TMR_H, 24'h000003);
		wait_tmr();
		chk(n_evt == 1 && last > 3 * bat_pkg::TICK_MULT * 2
			&& last <= 3 * bat_pkg::TICK_MULT * 2 + 4, "span");
		@(posedge aclk);
		chk(irq === 1'b1, "irq raised");
		axi_wr(bat_pkg::R_MASK, 32'h0);
		@(posedge aclk);
		chk(irq === 1'b0, "irq masked");
		axi_wr(bat_pkg::R_MASK, 32'h2);
		axi_wr(bat_pkg::R_INT, 32'h2);
		@(posedge aclk);
		chk(irq === 1'b0, "irq cleared");
		axi_rd(bat_pkg::R_INT, 32'h0, 32'h2, d);
		// Second start lands long before the first would expire
		cmd(bat_pkg::BAT_OP_WR2, bat_pkg::A_TMR_H, 24'h000004);
		cmd(bat_pkg::BAT_OP_WR2, bat_pkg::A_TMR_H, 24'h000002);
		wait_tmr();
		repeat (300) @(posedge aclk);
		chk(n_evt == 2 && last > 2 * bat_pkg::TICK_MULT * 2
			&& last <= 2 * bat_pkg::TICK_MULT * 2 + 4, "restart");
		$display("test timer done");
		end_sim();
	end
endmodule // buffer_access_timer_regs_tb_top
